// ===== src/cds_defines.svh
// Functional notes
// R1: timed contact: wait 300-900 ms, then primary
// R2: current contact: D+ fall starts primary
// R3: D+ voltage and D- sink switch together
// R4: primary: mask 40 ms, then sample charger
// R5: charger found: swap to secondary sources
// R6: secondary: mask 40 ms, then sample D+
// R7: confirm D- below upper threshold
// R8: host hardware: VBUS, detector, then drive D-
// R9: host hardware: stop D- on detect low
// R10: host timer: drive D- within 200 ms
// R11: host timer: release D- within 10 ms
// R12: detect change pulses irq, level readable
// R13: classify port as SDP, CDP or DCP
// R14: class from primary and secondary outcome
// R15: ms counter, restarted each step, reset cleared
`ifndef CDS_DEFINES_SVH
`define CDS_DEFINES_SVH

`define CDS_CLK_HZ 20000000
`define CDS_MS_PER_S 1000
`define CDS_MS_CYCLES (`CDS_CLK_HZ / `CDS_MS_PER_S)
`define CDS_MS_W 10
`define CDS_DCD_WAIT_MS 10'd300
`define CDS_DCD_MAX_MS 10'd900
`define CDS_MASK_MS 10'd40
`define CDS_DISC_DRIVE_MS 10'd200
`define CDS_CONN_RELEASE_MS 10'd10
`define CDS_LS_DP_BIT 0
`define CDS_LS_DM_BIT 1

`endif

// ===== src/cds_pkg.sv
package cds_pkg;
  typedef enum logic [2:0] {
    CDS_S_IDLE = 3'h0,
    CDS_S_DCD_CUR = 3'h1,
    CDS_S_PRI = 3'h3,
    CDS_S_SEC = 3'h2,
    CDS_S_DONE = 3'h6,
    CDS_S_DCD_TIME = 3'h4
  } cds_state_t;

  typedef enum logic [1:0] {
    CDS_PORT_NONE = 2'h0,
    CDS_PORT_SDP = 2'h1,
    CDS_PORT_CDP = 2'h2,
    CDS_PORT_DCP = 2'h3
  } cds_port_t;
endpackage : cds_pkg

// ===== src/cds_ms_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "cds_defines.svh"
module cds_ms_timer #(
  parameter int MS_CYCLES = `CDS_MS_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_restart,
  output logic [`CDS_MS_W-1:0] o_ms
);
  logic [31:0] cyc_r;
  logic [`CDS_MS_W-1:0] ms_r;

  if (MS_CYCLES < 1) begin : g_bad_div
    $error("MS_CYCLES must be at least 1");
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cyc_r <= 32'h0;
      ms_r <= '0;
    end else if (i_restart) begin
      cyc_r <= 32'h0;
      ms_r <= '0;
    end else if (cyc_r == 32'(MS_CYCLES - 1)) begin
      cyc_r <= 32'h0;
      if (ms_r != '1) begin
        ms_r <= ms_r + 1'b1;
      end
    end else begin
      cyc_r <= cyc_r + 32'h1;
    end
  end

  assign o_ms = ms_r;
endmodule : cds_ms_timer
`default_nettype wire

// ===== src/cds_sequencer.sv
`timescale 1ns/10ps
`default_nettype none
`include "cds_defines.svh"
module cds_sequencer
  import cds_pkg::*;
#(
  parameter int MS_CYCLES = `CDS_MS_CYCLES
) (
  input wire logic i_sys_clk,
  input wire logic i_rstn,
  input wire logic i_role_host,
  input wire logic i_dcd_cur_method,
  input wire logic i_host_timer_method,
  input wire logic i_dm_upper_check_en,
  input wire logic i_vbus_present_flag,
  input wire logic [1:0] i_line_state_bits,
  input wire logic i_charger_found_flag,
  input wire logic i_portable_detect_flag,
  input wire logic i_connected,
  output logic o_vbus_change_irq,
  output logic o_dplus_volt_src_en,
  output logic o_dminus_cur_sink_en,
  output logic o_dplus_cur_src_en,
  output logic o_dminus_volt_src_en,
  output logic o_dplus_cur_sink_en,
  output logic o_vbus_drive,
  output logic o_portable_det_en,
  output logic o_dminus_drive,
  output logic o_portable_detect_irq,
  output logic o_portable_detect_sts,
  output logic [1:0] o_port_class,
  output logic o_done
);
  cds_state_t state_r, state_nxt;
  cds_port_t class_r, class_nxt;
  logic [`CDS_MS_W-1:0] ms_cnt;
  logic vbus_r, dp_r, pd_r;
  logic pri_en_r, sec_en_r, cur_en_r;
  logic charger_ok;

  // millisecond base, restarted whenever the sequence moves
  cds_ms_timer #(.MS_CYCLES(MS_CYCLES)) u_timer ( // [R15]
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_restart(state_nxt != state_r),
    .o_ms(ms_cnt)
  );

  // with i_dm_upper_check_en set, charger accepted only if D- also stays below upper threshold
  assign charger_ok = i_charger_found_flag &&
    !(i_dm_upper_check_en && i_line_state_bits[`CDS_LS_DM_BIT]); // [R7]

  always_comb begin
    state_nxt = state_r;
    class_nxt = class_r;
    if (i_role_host || !i_vbus_present_flag) begin
      state_nxt = CDS_S_IDLE;
      class_nxt = CDS_PORT_NONE;
    end else begin
      unique case (state_r)
        CDS_S_IDLE: begin
          if (!vbus_r) begin
            state_nxt = i_dcd_cur_method ? CDS_S_DCD_CUR : CDS_S_DCD_TIME;
          end
        end
        CDS_S_DCD_TIME: begin
          if (ms_cnt >= `CDS_DCD_WAIT_MS) begin // [R1]
            state_nxt = CDS_S_PRI;
          end
        end
        CDS_S_DCD_CUR: begin
          if (dp_r && !i_line_state_bits[`CDS_LS_DP_BIT]) begin // [R2]
            state_nxt = CDS_S_PRI;
          end
        end
        CDS_S_PRI: begin
          if (ms_cnt >= `CDS_MASK_MS) begin // [R4]
            if (charger_ok) begin
              state_nxt = CDS_S_SEC; // [R5]
            end else begin
              state_nxt = CDS_S_DONE;
              class_nxt = CDS_PORT_SDP; // [R14]
            end
          end
        end
        CDS_S_SEC: begin
          if (ms_cnt >= `CDS_MASK_MS) begin // [R6]
            state_nxt = CDS_S_DONE;
            class_nxt = i_portable_detect_flag ? CDS_PORT_DCP : CDS_PORT_CDP; // [R13] [R14]
          end
        end
        CDS_S_DONE: begin
          state_nxt = CDS_S_DONE;
        end
        default: begin
          state_nxt = CDS_S_IDLE;
          class_nxt = CDS_PORT_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= CDS_S_IDLE;
      class_r <= CDS_PORT_NONE;
    end else begin
      state_r <= state_nxt;
      class_r <= class_nxt;
    end
  end

  // source enables decoded from the next state, so pairs move in one edge
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pri_en_r <= 1'b0;
      sec_en_r <= 1'b0;
      cur_en_r <= 1'b0;
    end else begin
      pri_en_r <= (state_nxt == CDS_S_PRI); // [R3]
      sec_en_r <= (state_nxt == CDS_S_SEC); // [R5]
      cur_en_r <= (state_nxt == CDS_S_DCD_CUR); // [R2]
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      vbus_r <= 1'b0;
      dp_r <= 1'b0;
      o_vbus_change_irq <= 1'b0;
    end else begin
      vbus_r <= i_vbus_present_flag;
      dp_r <= i_line_state_bits[`CDS_LS_DP_BIT];
      o_vbus_change_irq <= (vbus_r != i_vbus_present_flag);
    end
  end

  // charging downstream port role
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_vbus_drive <= 1'b0;
      o_portable_det_en <= 1'b0;
      o_dminus_drive <= 1'b0;
    end else begin
      o_vbus_drive <= i_role_host; // [R8]
      o_portable_det_en <= i_role_host && o_vbus_drive && !i_host_timer_method;
      if (!i_role_host) begin
        o_dminus_drive <= 1'b0;
      end else if (i_host_timer_method) begin
        o_dminus_drive <= !i_connected; // [R10] [R11]
      end else begin
        o_dminus_drive <= o_portable_det_en && i_portable_detect_flag; // [R8] [R9]
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pd_r <= 1'b0;
      o_portable_detect_irq <= 1'b0;
    end else begin
      pd_r <= i_portable_detect_flag;
      o_portable_detect_irq <= (pd_r != i_portable_detect_flag); // [R12]
    end
  end

  assign o_dplus_volt_src_en = pri_en_r;
  assign o_dminus_cur_sink_en = pri_en_r;
  assign o_dplus_cur_src_en = cur_en_r;
  assign o_dminus_volt_src_en = sec_en_r;
  assign o_dplus_cur_sink_en = sec_en_r;
  assign o_portable_detect_sts = pd_r;
  assign o_port_class = class_r;
  assign o_done = (state_r == CDS_S_DONE);

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rstn);

  AST_PRI_PAIR: assert property ( // [R3]
    o_dplus_volt_src_en == o_dminus_cur_sink_en)
    else $error("primary source and sink not switched together");

  AST_DCD_TIME_WAIT: assert property ( // [R1]
    $rose(o_dplus_volt_src_en) && $past(state_r) == CDS_S_DCD_TIME
    |-> $past(ms_cnt) >= `CDS_DCD_WAIT_MS && $past(ms_cnt) <= `CDS_DCD_MAX_MS)
    else $error("primary started outside contact wait window");

  AST_DCD_CUR_FALL: assert property ( // [R2]
    state_r == CDS_S_DCD_CUR && dp_r && !i_line_state_bits[`CDS_LS_DP_BIT]
    && i_vbus_present_flag && !i_role_host
    |=> o_dplus_volt_src_en && o_dminus_cur_sink_en && !o_dplus_cur_src_en)
    else $error("D+ fall did not hand over to primary sources");

  AST_PRI_MASK: assert property ( // [R4]
    state_r == CDS_S_PRI && ms_cnt < `CDS_MASK_MS |=> state_r != CDS_S_SEC && !o_done)
    else $error("primary result taken before mask elapsed");

  AST_SEC_SWAP: assert property ( // [R5]
    $rose(o_dminus_volt_src_en)
    |-> o_dplus_cur_sink_en && !o_dplus_volt_src_en && !o_dminus_cur_sink_en)
    else $error("secondary sources not swapped cleanly");

  AST_SEC_MASK: assert property ( // [R6]
    $rose(o_done) && $past(state_r) == CDS_S_SEC |-> $past(ms_cnt) >= `CDS_MASK_MS)
    else $error("secondary result taken before mask elapsed");

  AST_DM_UPPER: assert property ( // [R7]
    state_r == CDS_S_PRI && ms_cnt >= `CDS_MASK_MS && i_dm_upper_check_en
    && i_line_state_bits[`CDS_LS_DM_BIT] && i_vbus_present_flag && !i_role_host
    |=> o_done && o_port_class == CDS_PORT_SDP)
    else $error("charger accepted with D- above upper threshold");

  AST_HOST_ORDER: assert property ( // [R8]
    $rose(o_dminus_drive) && !i_host_timer_method |-> o_portable_det_en && o_vbus_drive)
    else $error("D- driven before VBUS and detector");

  AST_HW_STOP: assert property ( // [R9]
    i_role_host && !i_host_timer_method && !i_portable_detect_flag |=> !o_dminus_drive)
    else $error("D- still driven with detection low");

  AST_TMR_DRIVE: assert property ( // [R10] [R11]
    i_role_host && i_host_timer_method |=> o_dminus_drive == !$past(i_connected))
    else $error("timer-method D- drive wrong for connect state");

  AST_DET_CHANGE: assert property ( // [R12]
    i_portable_detect_flag != $past(i_portable_detect_flag)
    |=> o_portable_detect_irq && o_portable_detect_sts == $past(i_portable_detect_flag))
    else $error("detect change not flagged");

  AST_STEP_RESTART: assert property ( // [R15]
    state_r != $past(state_r) |-> ms_cnt == '0)
    else $error("ms counter not restarted at step");

  CVR_SDP: cover property ($rose(o_done) && o_port_class == CDS_PORT_SDP);
  CVR_CDP: cover property ($rose(o_done) && o_port_class == CDS_PORT_CDP);
  CVR_DCP: cover property ($rose(o_done) && o_port_class == CDS_PORT_DCP);
  CVR_HOST_DRIVE: cover property ($rose(o_dminus_drive) && !i_host_timer_method);
endmodule : cds_sequencer
`default_nettype wire

// ===== testbench/cds_port_model.sv
`timescale 1ns/10ps
`default_nettype none
module cds_port_model
  import cds_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_host,
  input wire logic [1:0] i_kind,
  input wire logic i_dm_high,
  input wire logic [7:0] i_contact_dly,
  input wire logic i_pd_host,
  input wire logic i_dp_cur_src,
  input wire logic i_dp_volt_src,
  input wire logic i_dm_volt_src,
  output logic [1:0] o_line_state_bits,
  output logic o_charger_found_flag,
  output logic o_portable_detect_flag
);
  logic [7:0] contact_r = 8'h00;
  // d+ held high by the source until the host pull-down makes contact
  always @(posedge i_sys_clk) begin
    contact_r <= i_dp_cur_src ? contact_r + 8'h01 : 8'h00;
  end
  always_comb begin
    o_line_state_bits = {i_dm_high, i_dp_cur_src && contact_r < i_contact_dly};
    o_charger_found_flag = i_dp_volt_src && i_kind != CDS_PORT_SDP;
    // dedicated port shorts d+ to d-, so d- source shows on d+
    o_portable_detect_flag = i_host ? i_pd_host : i_dm_volt_src && i_kind == CDS_PORT_DCP;
  end
endmodule : cds_port_model
`default_nettype wire

// ===== testbench/cds_sequencer_tb.sv
`timescale 1ns/10ps
`default_nettype none
module cds_sequencer_tb;
  import cds_pkg::*;
  localparam int MSC = 10;
  logic i_sys_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic role = 1'b0, dcd_cur = 1'b1, tmr = 1'b0, vbus = 1'b0, conn = 1'b0;
  logic dm_high = 1'b0, pd_host = 1'b0, dm_chk = 1'b1;
  logic [1:0] kind = 2'h1;
  logic [7:0] cdly = 8'h04;
  logic [1:0] ls, cls;
  logic chg, pdf, virq, pvs, dmsk, dps, dmv, dpsk, vdr, pden, dmd, pirq, psts, done;
  int n_errors = 0;
  int n_compared = 0;
  always #25 i_sys_clk = ~i_sys_clk;
  cds_sequencer #(.MS_CYCLES(MSC)) cds_sequencer_inst (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_role_host(role), .i_dcd_cur_method(dcd_cur), .i_host_timer_method(tmr),
    .i_dm_upper_check_en(dm_chk), .i_vbus_present_flag(vbus), .i_line_state_bits(ls),
    .i_charger_found_flag(chg), .i_portable_detect_flag(pdf), .i_connected(conn),
    .o_vbus_change_irq(virq), .o_dplus_volt_src_en(pvs), .o_dminus_cur_sink_en(dmsk),
    .o_dplus_cur_src_en(dps), .o_dminus_volt_src_en(dmv), .o_dplus_cur_sink_en(dpsk),
    .o_vbus_drive(vdr), .o_portable_det_en(pden), .o_dminus_drive(dmd),
    .o_portable_detect_irq(pirq), .o_portable_detect_sts(psts), .o_port_class(cls),
    .o_done(done));
  cds_port_model cds_port_model_inst (.i_sys_clk(i_sys_clk), .i_host(role), .i_kind(kind),
    .i_dm_high(dm_high), .i_contact_dly(cdly), .i_pd_host(pd_host), .i_dp_cur_src(dps),
    .i_dp_volt_src(pvs), .i_dm_volt_src(dmv), .o_line_state_bits(ls),
    .o_charger_found_flag(chg), .o_portable_detect_flag(pdf));
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %b expected %b", $time, seen, exp);
    end
  endtask : check
  task automatic tally_and_finish;
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  // counts falling edges until the level shows, bounded
  task automatic wait_lv(ref logic s, input logic lv, input int lim, output int n);
    n = 0;
    while (s !== lv && n < lim) begin
      @(negedge i_sys_clk);
      n++;
    end
  endtask : wait_lv
  function automatic logic [1:0] exp_class(logic [1:0] k, logic dmh);
    if (k == CDS_PORT_SDP || dmh) return CDS_PORT_SDP;
    return k;
  endfunction : exp_class
  task automatic dev_run(input logic cur, input logic [1:0] k, input logic dmh,
    input logic chk);
    int n;
    @(posedge i_sys_clk);
    dcd_cur <= cur;
    kind <= k;
    dm_high <= dmh;
    dm_chk <= chk;
    cdly <= 8'($urandom_range(60, 2));
    vbus <= 1'b1;
    if (cur) begin
      wait_lv(dps, 1'b1, 5, n);
      check(2'(n <= 2), 2'h1);
    end
    wait_lv(pvs, 1'b1, 4000, n);
    if (!cur) check(2'(n >= 3000 && n <= 3004), 2'h1);
    check(2'(dps), 2'h0);
    if (exp_class(k, dmh && chk) != CDS_PORT_SDP) begin
      wait_lv(dmv, 1'b1, 500, n);
      check(2'(n >= 400 && n <= 402), 2'h1);
      check(2'(pvs), 2'h0);
    end
    wait_lv(done, 1'b1, 500, n);
    check(2'(n >= 400 && n <= 402), 2'h1);
    check(cls, exp_class(k, dmh && chk));
    @(posedge i_sys_clk);
    vbus <= 1'b0;
    repeat (2) @(negedge i_sys_clk);
    check(2'(virq), 2'h1);
    @(negedge i_sys_clk);
    check({done, pvs | dmv}, 2'h0);
    check(cls, CDS_PORT_NONE);
  endtask : dev_run
  // primary and secondary pairs must never split
  always @(negedge i_sys_clk) begin
    if (i_rstn) check({pvs, dmv}, {dmsk, dpsk});
  end
  initial begin
    repeat (60000) @(posedge i_sys_clk);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    int n;
    void'($urandom(32'hc9522305));
    repeat (12) @(posedge i_sys_clk);
    i_rstn <= 1'b1;
    dev_run(1'b0, CDS_PORT_CDP, 1'b0, 1'b1);
    dev_run(1'b1, CDS_PORT_DCP, 1'b0, 1'b1);
    dev_run(1'b1, CDS_PORT_CDP, 1'b1, 1'b1);
    dev_run(1'b1, CDS_PORT_CDP, 1'b1, 1'b0);
    repeat (4) dev_run(1'($urandom), 2'($urandom_range(3, 1)), 1'($urandom), 1'($urandom));
    @(posedge i_sys_clk);
    role <= 1'b1;
    @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    check({vdr, pden}, 2'h2);
    @(negedge i_sys_clk);
    check({pden, dmd}, 2'h2);
    @(posedge i_sys_clk);
    pd_host <= 1'b1;
    @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    check({dmd, pirq}, 2'h3);
    check(2'(psts), 2'h1);
    @(posedge i_sys_clk);
    pd_host <= 1'b0;
    @(negedge i_sys_clk);
    @(negedge i_sys_clk);
    check({dmd, pirq}, 2'h1);
    check(2'(psts), 2'h0);
    @(posedge i_sys_clk);
    tmr <= 1'b1;
    wait_lv(dmd, 1'b1, 2000, n);
    check(2'(n < 2000), 2'h1);
    @(posedge i_sys_clk);
    conn <= 1'b1;
    wait_lv(dmd, 1'b0, 100, n);
    check(2'(n < 100), 2'h1);
    @(posedge i_sys_clk);
    conn <= 1'b0;
    wait_lv(dmd, 1'b1, 2000, n);
    check(2'(n < 2000), 2'h1);
    tally_and_finish();
  end
endmodule : cds_sequencer_tb
`default_nettype wire
